// ### verilog/dual_legacy_counter_timer.sv
`include "dual_timer_cfg.svh"
`default_nettype none


module dual_legacy_counter_timer #(
  parameter int ADDR_W = 5  // APB address width, at least five bits
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              t0_event_pin,
  input  wire logic              t1_event_pin,
  input  wire logic              ext_irq0_n,
  input  wire logic              ext_irq1_n,
  input  wire logic              ext_osc_clock,
  input  wire logic              t0_irq_ack,
  input  wire logic              t1_irq_ack,
  output logic                   t0_irq,
  output logic                   t1_irq,
  output logic                   t0_ovf_pulse,
  output logic                   t1_ovf_pulse
);
  import dual_timer_pkg::*;

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  if (ADDR_W < 5) begin : g_bad_addr_w
    $error("ADDR_W must be at least 5");
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [`PIN_COUNT-1:0] pin_raw;    // Asynchronous pins gathered
  logic [`PIN_COUNT-1:0] pin_level;  // Accepted levels
  logic [`PIN_COUNT-1:0] pin_fall;   // Accepted falling edges

  assign pin_raw[`PIN_T0_EVENT] = t0_event_pin;
  assign pin_raw[`PIN_T1_EVENT] = t1_event_pin;
  assign pin_raw[`PIN_IRQ0]     = ext_irq0_n;
  assign pin_raw[`PIN_IRQ1]     = ext_irq1_n;
  assign pin_raw[`PIN_EXT_OSC]  = ext_osc_clock;

  // Each pin passes three flops; the latency of four cycles is the price of
  // safe sampling, and limits event rates to a quarter of the clock
  for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
    pin_sync #(
      .IDLE_LEVEL (1'b1)
    ) u_sync (
      .core_clk  (core_clk),
      .srst      (srst),
      .pin_async (pin_raw[i]),
      .level     (pin_level[i]),
      .fall      (pin_fall[i])
    );
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] mode_ff;       // timer_mode_reg
  logic [7:0] clock_ff;      // clock_control_reg
  logic       t0_run_ff;     // t0_run_bit
  logic       t1_run_ff;     // t1_run_bit
  logic       t0_flag_ff;    // t0_overflow_flag
  logic       t1_flag_ff;    // t1_overflow_flag
  logic       t0_en_ff;      // t0_irq_enable
  logic       t1_en_ff;      // t1_irq_enable
  count_s     t0_cnt_ff;     // Timer 0 count bytes
  count_s     t1_cnt_ff;     // Timer 1 count bytes
  logic [3:0] div12_ff;      // Divide-by-12 counter
  logic [1:0] div4_ff;       // Divide-by-4 counter
  logic [5:0] div48_ff;      // Divide-by-48 counter
  logic [2:0] ext8_ff;       // External oscillator edge counter
  logic       t0_ovf_ff;     // Registered overflow pulse, timer 0
  logic       t1_ovf_ff;     // Registered overflow pulse, timer 1
  logic [7:0] rdata_ff;      // Read data captured in setup phase

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic [4:0] addr_lo;       // Word offset bits
  logic       upper_zero;    // Bits above the map are zero
  logic       hit_control;
  logic       hit_mode;
  logic       hit_clock;
  logic       hit_irq_en;
  logic       hit_t0_low;
  logic       hit_t0_high;
  logic       hit_t1_low;
  logic       hit_t1_high;
  logic       addr_hit;      // Any mapped register
  logic       setup_phase;   // First cycle of a transfer
  logic       wr_en;         // Write takes effect this edge

  assign addr_lo     = paddr[4:0];
  assign upper_zero  = (paddr >> 5) == '0;
  assign hit_control = upper_zero & (addr_lo == `OFS_CONTROL);
  assign hit_mode    = upper_zero & (addr_lo == `OFS_MODE);
  assign hit_clock   = upper_zero & (addr_lo == `OFS_CLOCK);
  assign hit_irq_en  = upper_zero & (addr_lo == `OFS_IRQ_EN);
  assign hit_t0_low  = upper_zero & (addr_lo == `OFS_T0_LOW);
  assign hit_t0_high = upper_zero & (addr_lo == `OFS_T0_HIGH);
  assign hit_t1_low  = upper_zero & (addr_lo == `OFS_T1_LOW);
  assign hit_t1_high = upper_zero & (addr_lo == `OFS_T1_HIGH);
  assign addr_hit    = hit_control | hit_mode | hit_clock | hit_irq_en |
                       hit_t0_low | hit_t0_high | hit_t1_low | hit_t1_high;
  assign setup_phase = psel & ~penable;
  // Only byte lane 0 carries data; writes with lane 0 off are dropped
  assign wr_en       = psel & penable & pwrite & pstrb[0] & addr_hit;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata  = {24'h000000, rdata_ff};

  // --------------------------------------------------------------------------
  // Read views
  // --------------------------------------------------------------------------
  logic [7:0] control_view;  // timer_control_reg as read
  logic [7:0] irq_en_view;   // interrupt_enable_reg as read
  logic [7:0] read_byte;     // Selected read value

  // Unused bits of these two registers read as zero
  always_comb begin
    control_view                = 8'h00;
    control_view[`CTRL_T0_RUN]  = t0_run_ff;
    control_view[`CTRL_T0_FLAG] = t0_flag_ff;
    control_view[`CTRL_T1_RUN]  = t1_run_ff;
    control_view[`CTRL_T1_FLAG] = t1_flag_ff;
    irq_en_view                 = 8'h00;
    irq_en_view[`IE_T0_BIT]     = t0_en_ff;
    irq_en_view[`IE_T1_BIT]     = t1_en_ff;
  end

  // Low byte bits 7:5 read back raw in 13-bit mode; callers mask them
  assign read_byte = hit_control ? control_view   :
                     hit_mode    ? mode_ff        :
                     hit_clock   ? clock_ff       :
                     hit_irq_en  ? irq_en_view    :
                     hit_t0_low  ? t0_cnt_ff.low  :
                     hit_t0_high ? t0_cnt_ff.high :
                     hit_t1_low  ? t1_cnt_ff.low  :
                     hit_t1_high ? t1_cnt_ff.high : 8'h00;

  // --------------------------------------------------------------------------
  // Configuration fields
  // --------------------------------------------------------------------------
  timer_cfg_s t0_cfg;        // Timer 0 nibble
  timer_cfg_s t1_cfg;        // Timer 1 nibble
  logic       t0_sys;        // t0_system_clock_select
  logic       t1_sys;        // t1_system_clock_select
  logic [1:0] prescale_field;
  logic       split;         // Timer 0 in split mode

  assign t0_cfg         = timer_cfg_s'(mode_ff[3:0]);
  assign t1_cfg         = timer_cfg_s'(mode_ff[7:4]);
  assign t0_sys         = clock_ff[`CLK_T0_SYS];
  assign t1_sys         = clock_ff[`CLK_T1_SYS];
  assign prescale_field = clock_ff[1:0];
  assign split          = (t0_cfg.mode == MODE_SPLIT);

  // --------------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------------
  logic tick12;              // System clock / 12
  logic tick4;               // System clock / 4
  logic tick48;              // System clock / 48
  logic tick_ext8;           // External oscillator / 8
  logic pre_tick;            // Selected prescaled tick

  assign tick12    = (div12_ff == `DIV12_LAST);
  assign tick4     = (div4_ff == `DIV4_LAST);
  assign tick48    = (div48_ff == `DIV48_LAST);
  // External oscillator must run well below a quarter of the clock
  assign tick_ext8 = pin_fall[`PIN_EXT_OSC] & (ext8_ff == `EXT8_LAST);
  assign pre_tick  = (prescale_field == 2'b00) ? tick12 :
                     (prescale_field == 2'b01) ? tick4  :
                     (prescale_field == 2'b10) ? tick48 : tick_ext8;

  // --------------------------------------------------------------------------
  // Count enables
  // --------------------------------------------------------------------------
  logic t0_int_tick;         // Timer 0 internal source
  logic t1_int_tick;         // Timer 1 internal source
  logic t0_tick;             // Timer 0 selected source
  logic t1_tick;             // Timer 1 selected source
  logic t0_allow;            // Run and gate agree, timer 0
  logic t1_allow;            // Run and gate agree, timer 1
  logic t0_go;               // Timer 0 (or its low half) counts now
  logic t1_go;               // Timer 1 counts now
  logic hi_go;               // Split-mode high half counts now

  assign t0_int_tick = t0_sys | pre_tick;
  assign t1_int_tick = t1_sys | pre_tick;
  assign t0_tick     = t0_cfg.counter_sel ? pin_fall[`PIN_T0_EVENT] : t0_int_tick;
  assign t1_tick     = t1_cfg.counter_sel ? pin_fall[`PIN_T1_EVENT] : t1_int_tick;
  assign t0_allow    = t0_run_ff & (~t0_cfg.gate | pin_level[`PIN_IRQ0]);
  assign t1_allow    = t1_run_ff & (~t1_cfg.gate | pin_level[`PIN_IRQ1]);
  assign t0_go       = t0_allow & t0_tick;

  // With timer 0 split, timer 1 loses its run bit and pins and runs
  // whenever its own mode is not split
  assign t1_go = (t1_cfg.mode == MODE_SPLIT) ? 1'b0 :
                 split ? t1_int_tick : (t1_allow & t1_tick);
  assign hi_go = split & t1_run_ff & t0_int_tick;

  // --------------------------------------------------------------------------
  // Increment step
  // --------------------------------------------------------------------------
  // One increment of a count pair in the given mode; the split case only
  // advances the low half, the high half is handled apart
  function automatic step_s count_step(input timer_mode_e mode, input count_s cur);
    step_s r;
    r.cnt = cur;
    r.ovf = 1'b0;
    case (mode)
      MODE_13BIT: begin
        {r.ovf, r.cnt.high, r.cnt.low[4:0]} = {1'b0, cur.high, cur.low[4:0]} + 14'h0001;
      end
      MODE_16BIT: begin
        {r.ovf, r.cnt} = {1'b0, cur} + 17'h00001;
      end
      MODE_RELOAD8: begin
        {r.ovf, r.cnt.low} = {1'b0, cur.low} + 9'h001;
        if (r.ovf) begin
          r.cnt.low = cur.high;
        end
      end
      default: begin
        {r.ovf, r.cnt.low} = {1'b0, cur.low} + 9'h001;
      end
    endcase
    return r;
  endfunction

  step_s      t0_step;       // Timer 0 incremented
  step_s      t1_step;       // Timer 1 incremented
  logic [8:0] hi_sum;        // Split-mode high half incremented
  logic       t0_flag_set;
  logic       t1_flag_set;

  assign t0_step     = count_step(t0_cfg.mode, t0_cnt_ff);
  assign t1_step     = count_step(t1_cfg.mode, t1_cnt_ff);
  assign hi_sum      = {1'b0, t0_cnt_ff.high} + 9'h001;
  assign t0_flag_set = t0_go & t0_step.ovf;
  // In split mode only the high half of timer 0 may raise timer 1's flag
  assign t1_flag_set = split ? (hi_go & hi_sum[8]) : (t1_go & t1_step.ovf);

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  count_s nxt_t0_cnt_ff;
  count_s nxt_t1_cnt_ff;
  logic   nxt_t0_flag_ff;
  logic   nxt_t1_flag_ff;

  // Software byte writes win over a simultaneous increment of that byte;
  // run bit changes never touch the count
  always_comb begin
    nxt_t0_cnt_ff = t0_cnt_ff;
    nxt_t1_cnt_ff = t1_cnt_ff;
    if (t0_go) begin
      nxt_t0_cnt_ff = t0_step.cnt;
    end
    if (hi_go) begin
      nxt_t0_cnt_ff.high = hi_sum[7:0];
    end
    if (t1_go) begin
      nxt_t1_cnt_ff = t1_step.cnt;
    end
    if (wr_en & hit_t0_low) begin
      nxt_t0_cnt_ff.low = pwdata[7:0];
    end
    if (wr_en & hit_t0_high) begin
      nxt_t0_cnt_ff.high = pwdata[7:0];
    end
    if (wr_en & hit_t1_low) begin
      nxt_t1_cnt_ff.low = pwdata[7:0];
    end
    if (wr_en & hit_t1_high) begin
      nxt_t1_cnt_ff.high = pwdata[7:0];
    end
  end

  // Flags: a hardware set in the same cycle as a clear always wins
  assign nxt_t0_flag_ff = t0_flag_set |
    ((wr_en & hit_control) ? pwdata[`CTRL_T0_FLAG] : (t0_flag_ff & ~t0_irq_ack));
  assign nxt_t1_flag_ff = t1_flag_set |
    ((wr_en & hit_control) ? pwdata[`CTRL_T1_FLAG] : (t1_flag_ff & ~t1_irq_ack));

  // --------------------------------------------------------------------------
  // Prescaler counters
  // --------------------------------------------------------------------------
  // Free running so the selected tick has a steady phase
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div12_ff <= 4'h0;
      div4_ff  <= 2'h0;
      div48_ff <= 6'h00;
      ext8_ff  <= 3'h0;
    end else begin
      div12_ff <= tick12 ? 4'h0 : div12_ff + 4'h1;
      div4_ff  <= div4_ff + 2'h1;
      div48_ff <= tick48 ? 6'h00 : div48_ff + 6'h01;
      ext8_ff  <= pin_fall[`PIN_EXT_OSC] ? ext8_ff + 3'h1 : ext8_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_ff   <= `RST_BYTE;
      clock_ff  <= `RST_BYTE;
      t0_run_ff <= 1'b0;
      t1_run_ff <= 1'b0;
      t0_en_ff  <= 1'b0;
      t1_en_ff  <= 1'b0;
    end else if (wr_en) begin
      mode_ff   <= hit_mode  ? pwdata[7:0] : mode_ff;
      clock_ff  <= hit_clock ? pwdata[7:0] : clock_ff;
      t0_run_ff <= hit_control ? pwdata[`CTRL_T0_RUN] : t0_run_ff;
      t1_run_ff <= hit_control ? pwdata[`CTRL_T1_RUN] : t1_run_ff;
      t0_en_ff  <= hit_irq_en ? pwdata[`IE_T0_BIT] : t0_en_ff;
      t1_en_ff  <= hit_irq_en ? pwdata[`IE_T1_BIT] : t1_en_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Counters, flags and read data
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      t0_cnt_ff  <= count_s'({`RST_BYTE, `RST_BYTE});
      t1_cnt_ff  <= count_s'({`RST_BYTE, `RST_BYTE});
      t0_flag_ff <= 1'b0;
      t1_flag_ff <= 1'b0;
      t0_ovf_ff  <= 1'b0;
      t1_ovf_ff  <= 1'b0;
      rdata_ff   <= 8'h00;
    end else begin
      t0_cnt_ff  <= nxt_t0_cnt_ff;
      t1_cnt_ff  <= nxt_t1_cnt_ff;
      t0_flag_ff <= nxt_t0_flag_ff;
      t1_flag_ff <= nxt_t1_flag_ff;
      t0_ovf_ff  <= t0_flag_set;
      // Timer 1 still pulses for baud use even while it cannot flag
      t1_ovf_ff  <= t1_go & t1_step.ovf;
      rdata_ff   <= setup_phase ? read_byte : rdata_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign t0_irq       = t0_flag_ff & t0_en_ff;
  assign t1_irq       = t1_flag_ff & t1_en_ff;
  assign t0_ovf_pulse = t0_ovf_ff;
  assign t1_ovf_pulse = t1_ovf_ff;

endmodule // dual_legacy_counter_timer

`default_nettype wire

// ### verilog/dual_timer_cfg.svh
`ifndef DUAL_TIMER_CFG_SVH
`define DUAL_TIMER_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the APB side)
// ----------------------------------------------------------------------------
`define OFS_CONTROL      5'h00
`define OFS_MODE         5'h04
`define OFS_CLOCK        5'h08
`define OFS_IRQ_EN       5'h0c
`define OFS_T0_LOW       5'h10
`define OFS_T0_HIGH      5'h14
`define OFS_T1_LOW       5'h18
`define OFS_T1_HIGH      5'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_T0_RUN      4
`define CTRL_T0_FLAG     5
`define CTRL_T1_RUN      6
`define CTRL_T1_FLAG     7
`define CLK_T0_SYS       3
`define CLK_T1_SYS       4
`define IE_T0_BIT        1
`define IE_T1_BIT        3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_BYTE         8'h00

// ----------------------------------------------------------------------------
// Prescaler terminal counts (divide by 12, 4, 48 and external by 8)
// ----------------------------------------------------------------------------
`define DIV12_LAST       4'hb
`define DIV4_LAST        2'h3
`define DIV48_LAST       6'h2f
`define EXT8_LAST        3'h7

// ----------------------------------------------------------------------------
// Synchronised pin indices
// ----------------------------------------------------------------------------
`define PIN_T0_EVENT     0
`define PIN_T1_EVENT     1
`define PIN_IRQ0         2
`define PIN_IRQ1         3
`define PIN_EXT_OSC      4
`define PIN_COUNT        5

`endif

// ### verilog/dual_timer_pkg.sv
`default_nettype none

package dual_timer_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  // Counting modes, two-bit field per timer
  typedef enum logic [1:0] {
    MODE_13BIT   = 2'b00,
    MODE_16BIT   = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT   = 2'b11
  } timer_mode_e;

  // One timer nibble of the mode register
  typedef struct packed {
    logic        gate;
    logic        counter_sel;
    timer_mode_e mode;
  } timer_cfg_s;

  // Count register as two bytes
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } count_s;

  // Result of one increment
  typedef struct packed {
    count_s cnt;
    logic   ovf;
  } step_s;

endpackage

`default_nettype wire

// ### verilog/pin_sync.sv
`default_nettype none

module pin_sync #(
  parameter logic IDLE_LEVEL = 1'b1  // Level assumed while in reset
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic pin_async,
  output logic      level,
  output logic      fall
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic stage1_ff;   // Metastability catcher, read only by stage2
  logic stage2_ff;   // Second stage
  logic stage3_ff;   // Third stage
  logic level_ff;    // Accepted level
  logic fall_ff;     // One-cycle pulse on accepted high-to-low
  logic agree;       // Second and third stage match

  assign agree = (stage2_ff == stage3_ff);

  // A change is taken only when two late stages agree; a level held two
  // cycles is thus always seen, shorter glitches may be dropped
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stage1_ff <= IDLE_LEVEL;
      stage2_ff <= IDLE_LEVEL;
      stage3_ff <= IDLE_LEVEL;
      level_ff  <= IDLE_LEVEL;
      fall_ff   <= 1'b0;
    end else begin
      stage1_ff <= pin_async;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff  <= agree ? stage2_ff : level_ff;
      fall_ff   <= agree & level_ff & ~stage2_ff;
    end
  end

  assign level = level_ff;
  assign fall  = fall_ff;

endmodule // pin_sync

`default_nettype wire

// ### testbench/dual_timer_checker_assertions.sv
`default_nettype none
// ---------------------------------------------
// Bus answer and timer flag checks
// ---------------------------------------------
module timer_checker #(
  parameter int ADDR_W = 8  // Must exceed five to decode the top bits
) (
  input wire logic              core_clk,
  input wire logic              srst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              t0_irq_ack,
  input wire logic              t0_irq,
  input wire logic              t0_ovf_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  wire logic acc = psel & penable;  // Access phase
  wire logic wr = acc & pwrite;     // Write access, may move flags
  // Setup then access of one read
  sequence s_read;
    psel && !penable && !pwrite ##1 acc;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_decode: assert property (acc && paddr[1:0] == 2'h0 |->
    pslverr == (paddr[ADDR_W-1:5] != '0)) else $error("bad decode");
  a_err_in_access: assert property (!acc |-> !pslverr) else $error("stray error");
  a_err_no_data: assert property (acc && pslverr |-> prdata == 32'h0) else $error("error data");
  a_read_byte: assert property (s_read |-> prdata[31:8] == 24'h0)
    else $error("upper read bits");
  a_irq_cause: assert property ($rose(t0_irq) |-> t0_ovf_pulse || $past(wr))
    else $error("irq without cause");
  a_irq_sticky: assert property (t0_irq && !t0_irq_ack && !wr |=> t0_irq)
    else $error("flag dropped");
  a_ack_clears: assert property (t0_irq_ack && !wr |=> !t0_irq || t0_ovf_pulse)
    else $error("ack ignored");
endmodule // timer_checker

bind dual_legacy_counter_timer timer_checker #(.ADDR_W(ADDR_W)) chk_u (
  .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .t0_irq_ack(t0_irq_ack), .t0_irq(t0_irq), .t0_ovf_pulse(t0_ovf_pulse));
`default_nettype wire

// ### testbench/event_pin_model.sv
`default_nettype none
// ---------------------------------------------
// External event source for the count pin
// ---------------------------------------------
module event_pin_model (
  input  wire logic core_clk,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b1;  // Idle high so no false edge at start
  // Each level held for hold cycles; two gives quarter clock rate
  task automatic pulses(input int n, input int hold);
    repeat (n) begin
      pin <= 1'b0;
      repeat (hold) @(posedge core_clk);
      pin <= 1'b1;
      repeat (hold) @(posedge core_clk);
    end
  endtask
endmodule // event_pin_model
`default_nettype wire

// ### testbench/dual_legacy_counter_timer_test.sv
`default_nettype none
module dual_legacy_counter_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------
  // Signals, rows and design
  // ---------------------------------------------
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ext_irq0_n = 1'b0;
  logic        ext_osc_clock = 1'b0;
  logic        t0_irq_ack = 1'b0;
  logic        ev0, pready, pslverr, t0_irq, t1_irq, t0_ovf_pulse, rerr;
  logic [31:0] prdata, rdata;
  int          fail_count = 0;
  int          checks = 0;
  int          div[4] = '{12, 4, 48, 64};  // Cycles per tick, ext clock is 8 cycles
  row_s        rows[8] = '{'{8'h04, 8'ha5, 8'ha5}, '{8'h08, 8'h1b, 8'h1b},
    '{8'h0c, 8'hff, 8'h0a}, '{8'h00, 8'h0f, 8'h00}, '{8'h10, 8'h5a, 8'h5a},
    '{8'h14, 8'hc3, 8'hc3}, '{8'h18, 8'h3c, 8'h3c}, '{8'h1c, 8'h96, 8'h96}};
  always #2 core_clk = ~core_clk;
  always #16 ext_osc_clock = ~ext_osc_clock;  // Toggles on falling core edges
  event_pin_model ev_u (.core_clk(core_clk), .pin(ev0));
  dual_legacy_counter_timer #(.ADDR_W(8)) dut_u (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .t0_event_pin(ev0), .t1_event_pin(1'b1), .ext_irq0_n(ext_irq0_n),
    .ext_irq1_n(1'b1), .ext_osc_clock(ext_osc_clock), .t0_irq_ack(t0_irq_ack),
    .t1_irq_ack(1'b0), .t0_irq(t0_irq), .t1_irq(t1_irq), .t0_ovf_pulse(t0_ovf_pulse),
    .t1_ovf_pulse());
  // ---------------------------------------------
  // Bus cycle, compare and verdict
  // ---------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge core_clk);
    if (n == 16) begin  // No answer ends the run
      fail_count++;
      print_verdict();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin  // A hang ends here as a mismatch
    repeat (100000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    int i;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    for (i = 0; i < 8; i++) begin  // Everything reads zero after reset
      apb(1'b0, 8'(i * 4), 8'h00);
      chk(rdata, 32'h0);
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 8'h00);
      chk(rdata, {24'h0, rows[i].e});
    end
    apb(1'b0, 8'h20, 8'h00);  // Unmapped place
    chk(32'(rerr), 32'h1);
    $display("registers done");
    apb(1'b1, 8'h08, 8'h08);  // Timer 0 on the system clock
    apb(1'b1, 8'h0c, 8'h02);
    for (i = 0; i < 2; i++) begin  // 13-bit then 16-bit wrap
      apb(1'b1, 8'h04, 8'(i));
      apb(1'b1, 8'h14, 8'hff);
      apb(1'b1, 8'h10, (i == 1) ? 8'hff : 8'h1f);
      apb(1'b1, 8'h00, 8'h10);
      repeat (8) @(posedge core_clk);
      chk(32'(t0_irq), 32'h1);
      apb(1'b1, 8'h00, 8'h20);  // Stop, flag kept
      apb(1'b0, 8'h14, 8'h00);
      chk(rdata, 32'h0);
    end
    repeat (5) @(negedge core_clk);
    chk(32'(t0_irq), 32'h1);
    apb(1'b1, 8'h0c, 8'h00);
    @(negedge core_clk);
    chk(32'(t0_irq), 32'h0);
    apb(1'b1, 8'h0c, 8'h02);
    t0_irq_ack <= 1'b1;
    @(posedge core_clk);
    t0_irq_ack <= 1'b0;
    @(negedge core_clk);
    chk(32'(t0_irq), 32'h0);
    $display("overflow done");
    apb(1'b1, 8'h04, 8'h0d);  // Gated 16-bit event counter
    apb(1'b1, 8'h10, 8'h10);
    apb(1'b1, 8'h00, 8'h10);
    apb(1'b0, 8'h10, 8'h00);
    chk(rdata, 32'h10);
    ev_u.pulses(3, 2);
    repeat (8) @(posedge core_clk);
    apb(1'b0, 8'h10, 8'h00);
    chk(rdata, 32'h10);
    ext_irq0_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    ev_u.pulses(5, 2);
    repeat (8) @(posedge core_clk);
    apb(1'b0, 8'h10, 8'h00);
    chk(rdata, 32'h15);
    $display("events done");
    apb(1'b1, 8'h04, 8'h01);
    for (i = 0; i < 4; i++) begin  // Run 480 cycles per prescale code
      apb(1'b1, 8'h08, 8'(i));
      apb(1'b1, 8'h10, 8'h00);
      apb(1'b1, 8'h00, 8'h10);
      repeat (477) @(posedge core_clk);
      apb(1'b1, 8'h00, 8'h00);
      apb(1'b0, 8'h10, 8'h00);
      chk(32'(rdata + 1 >= 480 / div[i] && rdata <= 480 / div[i] + 1), 32'h1);
    end
    $display("prescale done");
    apb(1'b1, 8'h08, 8'h08);  // 8-bit reload
    apb(1'b1, 8'h04, 8'h02);
    apb(1'b1, 8'h14, 8'hf0);
    apb(1'b1, 8'h10, 8'hfe);
    apb(1'b1, 8'h00, 8'h10);
    repeat (20) @(posedge core_clk);
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b0, 8'h14, 8'h00);
    chk(rdata, 32'hf0);
    apb(1'b0, 8'h10, 8'h00);
    chk(32'(rdata[7:4] == 4'hf), 32'h1);
    apb(1'b1, 8'h04, 8'h03);  // Split
    apb(1'b1, 8'h0c, 8'h08);
    apb(1'b1, 8'h14, 8'hff);
    apb(1'b1, 8'h00, 8'h40);
    repeat (4) @(posedge core_clk);
    chk(32'(t1_irq), 32'h1);
    $display("reload and split done");
    print_verdict();
  end
endmodule // dual_legacy_counter_timer_test
`default_nettype wire
